// File: rtl/tac_pkg.sv
`default_nettype none
package tac_pkg;

    // Register map of the plain programming port (byte addresses).
    localparam logic [7:0] TAC_ADDR_WIDTH_DUMMY = 8'h00;
    localparam logic [7:0] TAC_OFS_BASE_CTRL = 8'h00;
    localparam logic [7:0] TAC_OFS_ATTR_CTRL = 8'h04;
    localparam logic [7:0] TAC_OFS_STATUS = 8'h08;

    // Base control register field positions.
    localparam int TAC_EXT_ADDR_BIT = 31;
    localparam int TAC_PA_SIZE_LSB = 16;
    localparam int TAC_GRANULE_BIT = 14;
    localparam int TAC_SHARE_LSB = 12;
    localparam int TAC_OUTER_LSB = 10;

    // Attribute control register field positions.
    localparam int TAC_XLAT_EN_BIT = 0;
    localparam int TAC_WIDE_FMT_BIT = 1;
    localparam int TAC_MEM_ATTR_LSB = 4;

    // Fixed and reset values.
    localparam logic TAC_EXT_ADDR_VAL = 1'h1;
    localparam logic [2:0] TAC_PA_SIZE_VAL = 3'h2;
    localparam logic TAC_GRANULE_RST = 1'h0;
    localparam logic [1:0] TAC_SHARE_RST = 2'h0;
    localparam logic [1:0] TAC_OUTER_RST = 2'h0;
    localparam logic [3:0] TAC_MEM_ATTR_RST = 4'h0;
    localparam logic TAC_XLAT_EN_RST = 1'h0;
    localparam logic TAC_WIDE_FMT_RST = 1'h0;
    localparam logic TAC_OVR_ACTIVE_RST = 1'h1;

    // Decoded outer memory type.
    typedef enum logic [1:0] {
        TAC_OUT_DEVICE_CLASS,
        TAC_OUT_NONCACHE,
        TAC_OUT_WRITE_THROUGH,
        TAC_OUT_WRITE_BACK
    } tac_outer_type;

    // Decoded inner memory type.
    typedef enum logic [2:0] {
        TAC_IN_STRONGLY_ORDERED,
        TAC_IN_DEVICE,
        TAC_IN_RESERVED,
        TAC_IN_NONCACHE,
        TAC_IN_WRITE_THROUGH,
        TAC_IN_WRITE_BACK
    } tac_inner_type;

    // Walk configuration handed to the table walker.
    typedef struct packed {
        logic long_format;
        logic granule_64k;
        logic [1:0] shareability;
        logic [1:0] outer_cache;
        logic [2:0] pa_size;
    } tac_walk_cfg_type;

    // Attribute override handed to the transaction path.
    typedef struct packed {
        logic active;
        logic [1:0] outer_type;
        logic [2:0] inner_type;
    } tac_override_type;

endpackage : tac_pkg
`default_nettype wire

// File: rtl/tac_translation_attr_control.sv
// The address map and strobed register access were left to the implementer.
`default_nettype none
module tac_translation_attr_control
    import tac_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Programming port.
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Configuration outputs.
    output tac_walk_cfg_type walk_cfg_o,
    output tac_override_type override_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Software-visible state.

    logic granule_q, granule_d;
    logic [1:0] share_q, share_d;
    logic [1:0] outer_q, outer_d;
    logic xlat_en_q, xlat_en_d;
    logic wide_fmt_q, wide_fmt_d;
    logic [3:0] mem_attr_q, mem_attr_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] base_rd;
    logic [31:0] attr_rd;
    logic [31:0] status_rd;

    // Read images; every bit not assigned below is reserved and reads zero.
    always_comb begin
        base_rd = 32'h0;
        base_rd[TAC_EXT_ADDR_BIT] = TAC_EXT_ADDR_VAL;
        base_rd[TAC_PA_SIZE_LSB +: 3] = TAC_PA_SIZE_VAL;
        base_rd[TAC_GRANULE_BIT] = granule_q;
        base_rd[TAC_SHARE_LSB +: 2] = share_q;
        base_rd[TAC_OUTER_LSB +: 2] = outer_q;
        attr_rd = 32'h0;
        attr_rd[TAC_XLAT_EN_BIT] = xlat_en_q;
        attr_rd[TAC_WIDE_FMT_BIT] = wide_fmt_q;
        attr_rd[TAC_MEM_ATTR_LSB +: 4] = mem_attr_q;
        status_rd = 32'h0;
        status_rd[0] = walk_cfg_o.granule_64k;
        status_rd[1] = override_o.active;
        status_rd[3:2] = override_o.outer_type;
        status_rd[6:4] = override_o.inner_type;
    end

    // Register writes; fixed and reserved bits are simply never stored.
    always_comb begin
        granule_d = granule_q;
        share_d = share_q;
        outer_d = outer_q;
        xlat_en_d = xlat_en_q;
        wide_fmt_d = wide_fmt_q;
        mem_attr_d = mem_attr_q;
        rdata_d = 32'h0;
        if (wr_i && addr_i == TAC_OFS_BASE_CTRL) begin
            granule_d = wdata_i[TAC_GRANULE_BIT];
            share_d = wdata_i[TAC_SHARE_LSB +: 2];
            outer_d = wdata_i[TAC_OUTER_LSB +: 2];
        end
        if (wr_i && addr_i == TAC_OFS_ATTR_CTRL) begin
            xlat_en_d = wdata_i[TAC_XLAT_EN_BIT];
            wide_fmt_d = wdata_i[TAC_WIDE_FMT_BIT];
            mem_attr_d = wdata_i[TAC_MEM_ATTR_LSB +: 4];
        end
        // Unmapped addresses read as zero.
        if (rd_i) begin
            unique case (addr_i)
                TAC_OFS_BASE_CTRL: rdata_d = base_rd;
                TAC_OFS_ATTR_CTRL: rdata_d = attr_rd;
                TAC_OFS_STATUS: rdata_d = status_rd;
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // Register stage for software-visible state.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            granule_q <= TAC_GRANULE_RST;
            share_q <= TAC_SHARE_RST;
            outer_q <= TAC_OUTER_RST;
            xlat_en_q <= TAC_XLAT_EN_RST;
            wide_fmt_q <= TAC_WIDE_FMT_RST;
            mem_attr_q <= TAC_MEM_ATTR_RST;
            rdata_q <= 32'h0;
        end else begin
            granule_q <= granule_d;
            share_q <= share_d;
            outer_q <= outer_d;
            xlat_en_q <= xlat_en_d;
            wide_fmt_q <= wide_fmt_d;
            mem_attr_q <= mem_attr_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Decoded configuration, registered so outputs come from flip-flops.

    tac_walk_cfg_type walk_q, walk_d;
    tac_override_type ovr_q, ovr_d;

    // The walker only honours 64KB when both select bits agree; a lone
    // granule bit falls back to 4KB rather than walking a half-set format.
    always_comb begin
        walk_d.long_format = TAC_EXT_ADDR_VAL;
        walk_d.granule_64k = granule_q & wide_fmt_q;
        walk_d.shareability = share_q;
        walk_d.outer_cache = outer_q;
        walk_d.pa_size = TAC_PA_SIZE_VAL;
        ovr_d.active = ~xlat_en_q;
        unique case (mem_attr_q[3:2])
            2'h0: ovr_d.outer_type = TAC_OUT_DEVICE_CLASS;
            2'h1: ovr_d.outer_type = TAC_OUT_NONCACHE;
            2'h2: ovr_d.outer_type = TAC_OUT_WRITE_THROUGH;
            2'h3: ovr_d.outer_type = TAC_OUT_WRITE_BACK;
        endcase
        if (mem_attr_q[3:2] == 2'h0) begin
            ovr_d.inner_type = (mem_attr_q[1:0] == 2'h0) ?
                TAC_IN_STRONGLY_ORDERED : TAC_IN_DEVICE;
        end else begin
            unique case (mem_attr_q[1:0])
                2'h0: ovr_d.inner_type = TAC_IN_RESERVED;
                2'h1: ovr_d.inner_type = TAC_IN_NONCACHE;
                2'h2: ovr_d.inner_type = TAC_IN_WRITE_THROUGH;
                2'h3: ovr_d.inner_type = TAC_IN_WRITE_BACK;
            endcase
        end
    end

    // Register stage for decoded outputs.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            // Reset image matches what the decode yields from reset state.
            walk_q <= '{TAC_EXT_ADDR_VAL, TAC_GRANULE_RST, TAC_SHARE_RST, TAC_OUTER_RST,
                TAC_PA_SIZE_VAL};
            ovr_q <= '{TAC_OVR_ACTIVE_RST, 2'h0, 3'h0};
        end else begin
            walk_q <= walk_d;
            ovr_q <= ovr_d;
        end
    end

    assign walk_cfg_o = walk_q;
    assign override_o = ovr_q;

endmodule : tac_translation_attr_control
`default_nettype wire

// File: testbench/tac_translation_attr_control_assertions.sv
`default_nettype none
module tac_translation_attr_control_chk
    import tac_pkg::*;
(
    // Watched ports.
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire tac_walk_cfg_type walk_cfg_o,
    input wire tac_override_type override_o
);
    // One clock domain, so clocking and reset are stated once.
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic base_rd = rd_i && (addr_i == TAC_OFS_BASE_CTRL);
    wire logic base_wr = wr_i && (addr_i == TAC_OFS_BASE_CTRL);
    wire logic attr_wr = wr_i && (addr_i == TAC_OFS_ATTR_CTRL);
    ////////////////////////////////////////////////////////////////////////////////
    ext_flag_a: assert property (base_rd |=> rdata_o[31])
        else $error("flag bit not one");
    reserved_zero_a: assert property (base_rd |=> rdata_o[30:19] == 12'h0 && !rdata_o[15])
        else $error("reserved bits not zero");
    long_format_a: assert property (walk_cfg_o.long_format && walk_cfg_o.pa_size == 3'h2)
        else $error("fixed walk fields wrong");
    granule_small_a: assert property (base_wr && !wdata_i[14] |=> ##1 !walk_cfg_o.granule_64k)
        else $error("large granule without select");
    granule_reset_a: assert property ($rose(nrst_i) |-> !walk_cfg_o.granule_64k)
        else $error("granule not cleared by reset");
    walk_share_a: assert property (base_wr |=> ##1
        walk_cfg_o.shareability == $past(wdata_i[13:12], 2)) else $error("share wrong");
    walk_outer_a: assert property (base_wr |=> ##1
        walk_cfg_o.outer_cache == $past(wdata_i[11:10], 2)) else $error("outer wrong");
    override_gate_a: assert property (attr_wr |=> ##1
        override_o.active == !$past(wdata_i[0], 2)) else $error("override gate wrong");
endmodule : tac_translation_attr_control_chk
bind tac_translation_attr_control tac_translation_attr_control_chk chk_i (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .walk_cfg_o(walk_cfg_o), .override_o(override_o));
`default_nettype wire

// File: testbench/tac_translation_attr_control_tb.sv
`default_nettype none
module tac_translation_attr_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tac_pkg::*;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    tac_walk_cfg_type walk_cfg_o;
    tac_override_type override_o;
    int fails = 0;
    int samples_checked = 0;
    int seed = 32'h617A;
    logic [31:0] base_d;
    logic [31:0] attr_d;
    logic [8:0] exp_w;
    tac_translation_attr_control uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .walk_cfg_o(walk_cfg_o), .override_o(override_o));
    // Free-running 250 MHz clock.
    always #2 ref_clk_i = ~ref_clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h wanted %h", $time, what, got, exp);
        end
    endtask : chk
    // Strobes are left high so back-to-back writes never assign twice in one step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        rd_i <= 1'b0;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        addr_i <= a;
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp, "read");
    endtask : rd
    task automatic idle(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge ref_clk_i);
    endtask : idle
    // Expected override word: gate, outer type, inner type.
    function automatic logic [5:0] exp_ovr(input logic [31:0] a);
        logic [2:0] inner;
        if (a[7:6] == 2'h0) inner = (a[5:4] == 2'h0) ? 3'h0 : 3'h1;
        else inner = (a[5:4] == 2'h0) ? 3'h2 : {1'b0, a[5:4]} + 3'h2;
        return {~a[0], a[7:6], inner};
    endfunction : exp_ovr
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////////
    // Reset, then every attribute code with random control words.
    initial begin
        repeat (10) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        chk({23'h0, walk_cfg_o}, 32'h102, "reset walk");
        chk({26'h0, override_o}, 32'h20, "reset override");
        rd(TAC_OFS_BASE_CTRL, 32'h80020000);
        for (int i = 0; i < 32; i++) begin
            base_d = $random(seed);
            attr_d = $random(seed);
            attr_d[7:4] = i[3:0];
            wr(TAC_OFS_BASE_CTRL, base_d);
            wr(TAC_OFS_ATTR_CTRL, attr_d);
            idle(2);
            #1;
            exp_w = {1'b1, base_d[14] & attr_d[1], base_d[13:10], 3'h2};
            chk({23'h0, walk_cfg_o}, {23'h0, exp_w}, "walk");
            chk({31'h0, override_o.active}, {31'h0, ~attr_d[0]}, "gate");
            if (!attr_d[0]) chk({26'h0, override_o}, {26'h0, exp_ovr(attr_d)}, "dec");
            wr(8'h0C, 32'hFFFFFFFF);
            rd(TAC_OFS_BASE_CTRL, (base_d & 32'h00007C00) | 32'h80020000);
            rd(8'h0C, 32'h0);
            rd(TAC_OFS_ATTR_CTRL, attr_d & 32'h000000F3);
            rd(TAC_OFS_STATUS, {25'h0, exp_ovr(attr_d)[2:0], exp_ovr(attr_d)[4:3],
                ~attr_d[0], exp_w[7]});
        end
        close_out();
    end
    // Watchdog: the sequence needs well under 1000 cycles.
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        fails++;
        close_out();
    end
endmodule : tac_translation_attr_control_tb
`default_nettype wire
